// ---- rtl/pdc_pkg.sv ----
// pdc_pkg: constants and types for the parity dram board controller
// assumes a 50 MHz single clock and synchronous active-high reset in every user
package pdc_pkg;

  localparam int unsigned CLK_MHZ        = 50;
  localparam int unsigned REF_PERIOD_NS  = 14500;
  localparam int unsigned REF_HIGH_NS    = 6000;
  localparam int unsigned REF_EXTRA_NS   = 50;
  localparam int unsigned TAP_NS         = 20;
  localparam int unsigned PULSE_NS       = 230;
  localparam int unsigned REF_PERIOD_CYC = REF_PERIOD_NS * CLK_MHZ / 1000;
  localparam int unsigned REF_HIGH_CYC   = REF_HIGH_NS * CLK_MHZ / 1000;
  localparam int unsigned REF_EXTRA_CYC  = (REF_EXTRA_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TAP_CYC        = TAP_NS * CLK_MHZ / 1000;
  localparam int unsigned PULSE_CYC      = PULSE_NS * CLK_MHZ / 1000;
  // tap positions in cycles from trigger
  localparam logic [4:0] TAP_FIRST  = 5'h01;
  localparam logic [4:0] TAP_COLUMN = 5'h02;
  localparam logic [4:0] TAP_REFRAS = 5'h03;
  localparam logic [4:0] TAP_CHECK  = 5'h06;
  localparam logic [4:0] TAP_CLEAR  = 5'h09;
  localparam logic [4:0] SEQ_END    = 5'h0B;
  localparam logic [1:0] CTL_READ   = 2'h0;
  localparam logic [1:0] CTL_RPAUSE = 2'h1;
  localparam logic [1:0] CTL_WORDW  = 2'h2;
  localparam logic [1:0] CTL_BYTEW  = 2'h3;
  localparam int unsigned STAT_ERR_BIT   = 15;
  localparam int unsigned STAT_HIGH_BIT  = 14;
  localparam int unsigned STAT_WARN_BIT  = 0;
  localparam logic [15:0] STAT_RESET     = 16'h0000;
  localparam logic [21:0] PAGE_BASE_22   = 22'h3FE000;
  localparam logic [21:0] PAGE_BASE_18   = 22'h03E000;
  localparam logic [21:0] REG_ADDR_DEF   = 22'h3FF440;

  typedef enum logic [3:0] {
    PDC_IDLE = 4'h1,
    PDC_WAIT = 4'h2,
    PDC_SEQ  = 4'h4,
    PDC_DONE = 4'h8
  } pdc_state_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] rowStrobe;
    logic       colStrobe;
    logic [1:0] byteWrite;
    logic [15:0] wrData;
    logic [1:0]  wrParity;
  } pdc_dram_t;

endpackage : pdc_pkg

// ---- rtl/pdc_controller.sv ----
// pdc_controller: bus decode, sequencer, refresh and parity logic for one board
// assumes bus inputs are synchronous to clock and the dram array answers in one tap
`timescale 1ns/1ns
module pdc_controller
  import pdc_pkg::*;
#(
  parameter int unsigned REF_PERIOD = REF_PERIOD_CYC,
  parameter logic [21:0] REG_ADDR   = REG_ADDR_DEF
)(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        mode18,
  input  wire logic        powerLowLine_n,
  input  wire logic        masterSync,
  input  wire logic [21:0] busAddr,
  input  wire logic [1:0]  busCtl,
  input  wire logic [15:0] busDataIn,
  input  wire logic [15:0] dramRdData,
  input  wire logic [1:0]  dramRdParity,
  output pdc_dram_t        dram,
  output logic [15:0]      busDataOut,
  output logic             busDataOe_n,
  output logic             slaveSync,
  output logic             parityErrLine,
  output logic             errorLed,
  output logic             busy
);

  // tick high time scales with the period so a shortened period still gives a falling edge
  localparam int unsigned REF_HIGH = REF_PERIOD * REF_HIGH_NS / REF_PERIOD_NS;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic        powerLow     = ~powerLowLine_n;
  wire logic [21:0] effAddr      = mode18 ? {4'h0, busAddr[17:0]} : busAddr;
  wire logic [21:0] pageBase     = mode18 ? PAGE_BASE_18 : PAGE_BASE_22;
  wire logic        inPage       = effAddr >= pageBase;
  // 18-bit mode matches only the low address bits of the register address
  wire logic        registerSelect = mode18 ? (effAddr[17:1] == REG_ADDR[17:1]) :
                                              (effAddr[21:1] == REG_ADDR[21:1]);
  wire logic        memSel       = ~powerLow & ~slaveSync & ~inPage;
  wire logic        regSel       = ~powerLow & registerSelect;
  wire logic        memRequest   = masterSync & memSel;
  wire logic        regAccess    = masterSync & regSel;
  wire logic        isWrite      = busCtl[1];

  // ----------------------------------------------------------------
  // refresh tick and row counter
  // ----------------------------------------------------------------
  logic [15:0] tickCnt_r;
  logic        tick_r;
  logic        tickPrev_r;
  logic [6:0]  refRow_r;
  logic        refDone_r;
  wire logic   tickRise = tick_r & ~tickPrev_r;
  wire logic   tickFall = ~tick_r & tickPrev_r;

  always_ff @(posedge clock)
  begin
    if (rst || tickCnt_r == 16'(REF_PERIOD - 1))
      tickCnt_r <= 16'h0000;
    else
      tickCnt_r <= tickCnt_r + 16'h0001;
  end

  always_ff @(posedge clock)
  begin
    tick_r     <= rst ? 1'b0 : (tickCnt_r < 16'(REF_HIGH));
    tickPrev_r <= rst ? 1'b0 : tick_r;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      refRow_r <= 7'h00;
    else if (tickFall && refDone_r)
      refRow_r <= refRow_r + 7'h01;
  end

  // ----------------------------------------------------------------
  // arbitration and sequencer
  // ----------------------------------------------------------------
  pdc_state_t  state_r;
  pdc_state_t  state_nxt;
  logic        refReq_r;
  logic        refCycle_r;
  logic [4:0]  seqCnt_r;
  logic [1:0]  waitCnt_r;
  logic [21:0] latAddr_r;
  logic [1:0]  latCtl_r;
  logic [15:0] latData_r;

  wire logic   idle      = (state_r == PDC_IDLE);
  // memory request wins ties: it came with the bus waiting, refresh can slip
  wire logic   startMem  = idle & memRequest;
  wire logic   startRef  = idle & ~memRequest & refReq_r;
  wire logic   waitDone  = (waitCnt_r == 2'(REF_EXTRA_CYC - 1));
  wire logic   seqEnd    = (state_r == PDC_SEQ) && (seqCnt_r == SEQ_END);
  wire logic   clearTap  = (state_r == PDC_SEQ) && (seqCnt_r == TAP_CLEAR) && refCycle_r;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      PDC_IDLE: if (startRef) state_nxt = PDC_WAIT;
                else if (startMem) state_nxt = PDC_SEQ;
      PDC_WAIT: if (waitDone) state_nxt = PDC_SEQ;
      PDC_SEQ:  if (seqEnd) state_nxt = PDC_DONE;
      PDC_DONE: state_nxt = masterSync & ~refCycle_r & slaveSync ? PDC_DONE : PDC_IDLE;
      default:  state_nxt = PDC_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    state_r   <= rst ? PDC_IDLE : state_nxt;
    busy      <= rst ? 1'b0 : (state_nxt != PDC_IDLE);
    waitCnt_r <= (rst || state_r != PDC_WAIT) ? 2'h0 : waitCnt_r + 2'h1;
    seqCnt_r  <= (rst || state_r != PDC_SEQ) ? 5'h00 : seqCnt_r + 5'h01;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      refReq_r <= 1'b0;
    else if (tickRise)
      refReq_r <= 1'b1;
    else if (clearTap)
      refReq_r <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      refCycle_r <= 1'b0;
    else if (startRef || startMem)
      refCycle_r <= startRef;
    else if (seqEnd)
      refCycle_r <= 1'b0;  // cleared at seqEnd, so in PDC_DONE the tail of a refresh looks like a data cycle
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      refDone_r <= 1'b0;
    else if (clearTap)
      refDone_r <= 1'b1;
    else if (tickFall)
      refDone_r <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      latAddr_r <= 22'h000000;
      latCtl_r  <= CTL_READ;
      latData_r <= 16'h0000;
    end
    else if (startMem)
    begin
      latAddr_r <= effAddr;
      latCtl_r  <= busCtl;
      latData_r <= busDataIn;
    end
  end

  // ----------------------------------------------------------------
  // dram drive
  // ----------------------------------------------------------------
  wire logic   inSeq     = (state_r == PDC_SEQ);
  wire logic   colPhase  = inSeq && seqCnt_r >= TAP_COLUMN;
  wire logic   memCyc    = inSeq & ~refCycle_r;
  wire logic   latWrite  = latCtl_r[1];
  wire logic [2:0] bankSel = latAddr_r[17:15];
  wire logic [7:0] bankOneHot = 8'h01 << bankSel;
  wire logic [1:0] byteSel = (latCtl_r == CTL_BYTEW) ?
                             (latAddr_r[0] ? 2'b10 : 2'b01) : 2'b11;
  wire logic   refRas    = inSeq && refCycle_r && seqCnt_r >= TAP_REFRAS;

  always_ff @(posedge clock)
  begin
    if (rst)
      dram <= '0;
    else
    begin
      dram.addr      <= refCycle_r ? refRow_r :
                        (colPhase ? latAddr_r[7:1] : latAddr_r[14:8]);
      dram.rowStrobe <= refRas ? 8'hFF : (memCyc ? bankOneHot : 8'h00);
      dram.colStrobe <= memCyc && colPhase;
      dram.byteWrite <= (memCyc && latWrite && colPhase) ? byteSel : 2'b00;
      dram.wrData    <= latData_r;
      dram.wrParity  <= {^latData_r[15:8], ^latData_r[7:0]};
    end
  end

  // ----------------------------------------------------------------
  // status register and parity check
  // ----------------------------------------------------------------
  logic [15:0] stat_r;
  logic [3:0]  errHigh_r;
  wire logic   checkTap  = memCyc && ~latWrite && seqCnt_r == TAP_CHECK;
  wire logic [1:0] rdPar = {^dramRdData[15:8], ^dramRdData[7:0]};
  wire logic   parErr    = checkTap && (rdPar != dramRdParity);
  wire logic   regWrite  = regAccess & isWrite & ~slaveSync;
  wire logic [6:0] midBits = (stat_r[STAT_HIGH_BIT] && !mode18) ?
                             {3'h0, errHigh_r} : stat_r[11:5];
  wire logic [15:0] regRead = {stat_r[15], stat_r[STAT_HIGH_BIT] & ~mode18,
                               stat_r[13:12], midBits, stat_r[4:0]};

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      stat_r    <= STAT_RESET;
      errHigh_r <= 4'h0;
    end
    else if (parErr)
    begin
      stat_r[STAT_ERR_BIT] <= 1'b1;
      stat_r[11:5]         <= latAddr_r[17:11];
      errHigh_r            <= latAddr_r[21:18];
    end
    else if (regWrite)
    begin
      stat_r <= {busDataIn[15], busDataIn[14] & ~mode18, busDataIn[13:0]};
    end
  end

  always_ff @(posedge clock)
  begin
    errorLed      <= rst ? 1'b0 : stat_r[STAT_ERR_BIT] | parErr;
    parityErrLine <= rst ? 1'b0 : parErr & stat_r[STAT_WARN_BIT];
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  wire logic memAckW = memCyc && latWrite && seqCnt_r == TAP_FIRST;
  wire logic memAckR = memCyc && ~latWrite && seqCnt_r == TAP_CHECK;

  always_ff @(posedge clock)
  begin
    if (rst || !masterSync)
    begin
      slaveSync   <= 1'b0;
      busDataOe_n <= 1'b1;
      busDataOut  <= 16'h0000;
    end
    else if (regAccess && !slaveSync)
    begin
      slaveSync   <= 1'b1;
      busDataOe_n <= isWrite;
      busDataOut  <= regRead;
    end
    else if (memAckW || memAckR)
    begin
      slaveSync   <= 1'b1;
      busDataOe_n <= latWrite;
      busDataOut  <= dramRdData;
    end
  end

endmodule : pdc_controller

// ---- tb/pdc_dram_model.sv ----
// pdc_dram_model: behavioural storage array on the controller's dram port
// assumes a bank is picked by a single row strobe and the column arrives with the column strobe
`timescale 1ns/1ns
module pdc_dram_model
  import pdc_pkg::*;
(
  input  wire logic        clock,
  input  wire pdc_dram_t   dram,
  input  wire logic        badParity,
  output logic [15:0]      rdData,
  output logic [1:0]       rdParity
);
  logic [17:0] mem [int];
  logic [17:0] last;
  logic [6:0]  row;
  int          bank;
  int          key;
  initial last = 18'h00000;
  always @(posedge clock)
  begin
    if ($onehot(dram.rowStrobe) && !dram.colStrobe)
    begin
      row = dram.addr;
      bank = $clog2(dram.rowStrobe);
    end
    if (dram.colStrobe && $onehot(dram.rowStrobe))
    begin
      key = {bank[2:0], row, dram.addr};
      last = mem.exists(key) ? mem[key] : 18'h00000;
      if (dram.byteWrite[1]) last = {dram.wrParity[1], last[16], dram.wrData[15:8], last[7:0]};
      if (dram.byteWrite[0]) last = {last[17], dram.wrParity[0], last[15:8], dram.wrData[7:0]};
      mem[key] = last;
    end
  end
  // an idle array does not hold its last word, so stale reads show up
  assign rdData   = (|dram.rowStrobe) ? last[15:0] : ~last[15:0];
  assign rdParity = last[17:16] ^ {2{badParity}};
endmodule : pdc_dram_model

// ---- tb/pdc_controller_monitor.sv ----
// pdc_controller_monitor: port-level checks on the controller
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/1ns
module pdc_controller_monitor
  import pdc_pkg::*;
(
  input wire logic      clock,
  input wire logic      rst,
  input wire logic      powerLowLine_n,
  input wire logic      masterSync,
  input wire pdc_dram_t dram,
  input wire logic      busDataOe_n,
  input wire logic      slaveSync,
  input wire logic      parityErrLine,
  input wire logic      errorLed,
  input wire logic      busy
);
  logic       allRows;
  logic       allRows_r;
  logic       haveRow_r;
  logic [6:0] lastRow_r;
  assign allRows = (dram.rowStrobe == 8'hFF);
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      allRows_r <= 1'b0;
      haveRow_r <= 1'b0;
      lastRow_r <= 7'h00;
    end
    else
    begin
      allRows_r <= allRows;
      if (allRows && !allRows_r)
      begin
        haveRow_r <= 1'b1;
        lastRow_r <= dram.addr;
      end
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_busy_cover; (dram.rowStrobe != 8'h00) |-> busy; endproperty
  a_busy_cover: assert property (p_busy_cover) else $error("strobe outside busy");
  property p_ref_quiet; allRows |-> !dram.colStrobe && dram.byteWrite == 2'h0; endproperty
  a_ref_quiet: assert property (p_ref_quiet) else $error("column or write in refresh");
  property p_one_bank; dram.colStrobe |-> $onehot(dram.rowStrobe); endproperty
  a_one_bank: assert property (p_one_bank) else $error("column strobe without one bank");
  property p_wr_col; (dram.byteWrite != 2'h0) |-> dram.colStrobe; endproperty
  a_wr_col: assert property (p_wr_col) else $error("byte write without column");
  property p_oe_sync; !busDataOe_n |-> slaveSync; endproperty
  a_oe_sync: assert property (p_oe_sync) else $error("bus drive without slave sync");
  property p_release; !masterSync |=> !slaveSync; endproperty
  a_release: assert property (p_release) else $error("slave sync held after release");
  property p_power; !powerLowLine_n && !slaveSync |=> !slaveSync; endproperty
  a_power: assert property (p_power) else $error("answer during power low");
  property p_err; parityErrLine |-> ##[0:1] errorLed ##1 !parityErrLine; endproperty
  a_err: assert property (p_err) else $error("parity warning shape");
  property p_row_step; allRows && !allRows_r && haveRow_r |-> dram.addr == lastRow_r + 7'h01; endproperty
  a_row_step: assert property (p_row_step) else $error("refresh row not stepped");
  property p_end; $fell(busy) |-> dram.rowStrobe == 8'h00 && !dram.colStrobe; endproperty
  a_end: assert property (p_end) else $error("strobes alive after cycle");
  c_refresh: cover property (allRows);
  c_perr: cover property (parityErrLine);
  c_byte: cover property (dram.byteWrite == 2'h2);
endmodule : pdc_controller_monitor
bind pdc_controller pdc_controller_monitor u_mon (.clock(clock), .rst(rst), .powerLowLine_n(powerLowLine_n),
  .masterSync(masterSync), .dram(dram), .busDataOe_n(busDataOe_n), .slaveSync(slaveSync),
  .parityErrLine(parityErrLine), .errorLed(errorLed), .busy(busy));

// ---- tb/parity_dram_board_controller_tb_top.sv ----
// parity_dram_board_controller_tb_top: bus-master tasks and directed tests
// assumes the array model answers every read and the checker is bound to the controller
`timescale 1ns/1ns
module parity_dram_board_controller_tb_top
  import pdc_pkg::*;
;
  logic clock = 0, rst = 1, mode18 = 0, powerLowLine_n = 1, masterSync = 0, badParity = 0, ok;
  logic [21:0] busAddr = 22'h000000;
  logic [1:0]  busCtl = 2'h0, dramRdParity;
  logic [15:0] busDataIn = 16'h0000, dramRdData, busDataOut, rd;
  logic        busDataOe_n, slaveSync, parityErrLine, errorLed, busy;
  logic [6:0]  row0, row1;
  pdc_dram_t   dram;
  int          errors = 0, checks_done = 0, pulses = 0, waited;
  localparam logic [21:0] REG = 22'h3FF440;
  localparam logic [21:0] MA  = 22'h02A344;
  always #10 clock = ~clock;
  // shortened refresh period keeps the run brief
  pdc_controller #(.REF_PERIOD(200), .REG_ADDR(REG)) uut (.clock(clock), .rst(rst), .mode18(mode18),
    .powerLowLine_n(powerLowLine_n), .masterSync(masterSync), .busAddr(busAddr), .busCtl(busCtl),
    .busDataIn(busDataIn), .dramRdData(dramRdData), .dramRdParity(dramRdParity), .dram(dram),
    .busDataOut(busDataOut), .busDataOe_n(busDataOe_n), .slaveSync(slaveSync),
    .parityErrLine(parityErrLine), .errorLed(errorLed), .busy(busy));
  pdc_dram_model array (.clock(clock), .dram(dram), .badParity(badParity), .rdData(dramRdData),
    .rdParity(dramRdParity));
  task close_out;
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  // a refused transfer gives up after a bounded wait, as a bus timeout would
  task xfer(input logic [1:0] ctl, input logic [21:0] a, input logic [15:0] d);
    @(posedge clock);
    busCtl <= ctl;
    busAddr <= a;
    busDataIn <= d;
    masterSync <= 1'b1;
    ok = 1'b0;
    rd = 16'h0000;
    for (waited = 0; waited < 40 && !ok; waited++)
    begin
      @(posedge clock);
      if (parityErrLine === 1'b1) pulses++;
      if (slaveSync === 1'b1) {ok, rd} = {1'b1, busDataOut};
    end
    masterSync <= 1'b0;
    repeat (4)
    begin
      @(posedge clock);
      if (parityErrLine === 1'b1) pulses++;
    end
  endtask : xfer
  task wait_refresh(output logic [6:0] row);
    for (int n = 0; n < 400 && dram.rowStrobe !== 8'hFF; n++) @(posedge clock);
    row = dram.addr;
    check({13'h0, dram.colStrobe, dram.byteWrite}, 16'h0000);
    while (dram.rowStrobe === 8'hFF) @(posedge clock);
  endtask : wait_refresh
  initial
  begin
    #400000;
    errors++;
    close_out();
  end
  initial
  begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check({busDataOe_n, slaveSync, busy, 13'h0}, 16'h8000);
    xfer(CTL_BYTEW, REG, 16'h4001);
    xfer(CTL_RPAUSE, REG, 16'h0000);
    check(rd, 16'h4001);
    mode18 <= 1'b1;
    xfer(CTL_WORDW, 22'h03F440, 16'h4001);
    xfer(CTL_READ, REG, 16'h0000);
    check(rd, 16'h0001);
    xfer(CTL_WORDW, 22'h3C1234, 16'hBEEF);
    xfer(CTL_READ, 22'h001234, 16'h0000);
    check(rd, 16'hBEEF);
    mode18 <= 1'b0;
    xfer(CTL_WORDW, MA, 16'h1234);
    xfer(CTL_BYTEW, MA | 22'h1, 16'hAB00);
    xfer(CTL_READ, MA, 16'h0000);
    check(rd, 16'hAB34);
    xfer(CTL_BYTEW, MA, 16'h00CD);
    xfer(CTL_RPAUSE, MA, 16'h0000);
    check(rd, 16'hABCD);
    xfer(CTL_READ, 22'h3FE100, 16'h0000);
    check({15'h0, ok}, 16'h0000);
    powerLowLine_n <= 1'b0;
    xfer(CTL_READ, REG, 16'h0000);
    check({15'h0, ok}, 16'h0000);
    xfer(CTL_READ, MA, 16'h0000);
    check({15'h0, ok}, 16'h0000);
    powerLowLine_n <= 1'b1;
    wait_refresh(row0);
    wait_refresh(row1);
    check({9'h0, row1}, {9'h0, row0 + 7'h01});
    for (int n = 0; n < 400 && dram.rowStrobe !== 8'hFF; n++) @(posedge clock);
    xfer(CTL_READ, REG, 16'h0000);
    check({15'h0, waited <= 3}, 16'h0001);
    xfer(CTL_WORDW, REG, 16'h0000);
    pulses = 0;
    badParity <= 1'b1;
    xfer(CTL_READ, MA, 16'h0000);
    check(pulses, 16'h0000);
    check({15'h0, errorLed}, 16'h0001);
    xfer(CTL_WORDW, REG, 16'h0001);
    xfer(CTL_READ, MA, 16'h0000);
    badParity <= 1'b0;
    check(pulses, 16'h0001);
    xfer(CTL_READ, REG, 16'h0000);
    check(rd, 16'h8A81);
    close_out();
  end
endmodule : parity_dram_board_controller_tb_top
